/* design/tacu_cmd_unit.sv */
// terminal adapter command unit: host i/o, command execution, status
`timescale 1ns/1ps
`include "tacu_consts.svh"
module tacu_cmd_unit
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [9:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  output logic      [7:0]  io_rdata,
  input  wire logic        aux_change_evt,
  input  wire logic        unit_reset_evt,
  input  wire logic        cursor_set_evt,
  input  wire logic        key_slot_taken_evt,
  input  wire logic        buf_write_evt,
  input  wire logic [10:0] buf_wr_addr,
  input  wire logic [7:0]  buf_wr_data,
  input  wire logic [7:0]  watch_cur_data,
  output logic      [10:0] watch_addr,
  output logic      [7:0]  key_code,
  output logic             key_send,
  output logic      [7:0]  pen_row,
  output logic      [7:0]  screen_field_ident,
  output logic             pen_send,
  output logic             por_send,
  output logic             attention_req,
  output logic             cmd_pending
);

  // ----------------------------------------
  // host i/o decode
  // ----------------------------------------
  logic       sel_word;
  logic       sel_post;
  logic       sel_flags;
  logic [1:0] word_idx;
  logic       word_wr;

  assign sel_word  = (io_addr >= `TACU_PORT_WORD0) && (io_addr <= `TACU_PORT_WORD3);
  assign sel_post  = (io_addr == `TACU_PORT_CMD_POST);
  assign sel_flags = (io_addr == `TACU_PORT_FLAGS);
  assign word_idx  = io_addr[1:0];

  // array is frozen while a command runs so arguments stay stable
  assign word_wr = io_wr && sel_word && !cmd_pending;

  // ----------------------------------------
  // shared array
  // ----------------------------------------
  logic [7:0] mem_rdata;
  logic [7:0] word1;
  logic [7:0] word2;
  logic [7:0] word3;

  tacu_word_mem u_mem
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (word_wr),
    .wr_idx   (word_idx),
    .wr_data  (io_wdata),
    .rd_en    (io_rd && sel_word),
    .rd_idx   (word_idx),
    .rd_data  (mem_rdata),
    .word1    (word1),
    .word2    (word2),
    .word3    (word3)
  );

  // word 0 holds the selector as written; reads show status instead
  logic [7:0] cmd_sel;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_sel <= 8'h00;
    else if (word_wr && word_idx == 2'd0)
      cmd_sel <= io_wdata; // [R20]
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  tacu_pkg::tacu_state_t state;
  tacu_pkg::tacu_state_t next_state;
  logic                  exec;
  logic                  done;

  assign exec = (state == tacu_pkg::TACU_EXEC);
  assign done = (state == tacu_pkg::TACU_DONE);

  always_comb
  begin
    next_state = state;
    case (state)
      tacu_pkg::TACU_IDLE:
        if (cmd_pending)
          next_state = tacu_pkg::TACU_EXEC; // [R24]
      tacu_pkg::TACU_EXEC:
        next_state = tacu_pkg::TACU_DONE;
      tacu_pkg::TACU_DONE:
        next_state = tacu_pkg::TACU_IDLE;
      default:
        next_state = tacu_pkg::TACU_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state <= tacu_pkg::TACU_IDLE;
    else
      state <= next_state;
  end

  logic do_clr;
  logic do_key;
  logic do_pen;
  logic do_por;
  logic do_wdata;
  logic do_waddr;
  logic do_amask;

  assign do_clr   = exec && (cmd_sel == `TACU_CMD_CLR_STATUS);
  assign do_key   = exec && (cmd_sel == `TACU_CMD_SEND_KEY);
  assign do_pen   = exec && (cmd_sel == `TACU_CMD_SEND_PEN);
  assign do_por   = exec && (cmd_sel == `TACU_CMD_POR);
  assign do_wdata = exec && (cmd_sel == `TACU_CMD_WATCH_DATA);
  assign do_waddr = exec && (cmd_sel == `TACU_CMD_WATCH_ADDR);
  assign do_amask = exec && (cmd_sel == `TACU_CMD_ATTN_MASK);

  // ----------------------------------------
  // handshake flags
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_pending <= 1'b0;
    else if (io_wr && sel_post && !cmd_pending)
      cmd_pending <= 1'b1; // [R17] [R24]
    else if (done)
      cmd_pending <= 1'b0; // [R17]
  end

  // ----------------------------------------
  // controller side outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      key_code <= 8'h00;
      key_send <= 1'b0;
    end
    else
    begin
      key_send <= do_key; // [R5]
      if (do_key)
        key_code <= word3; // [R5]
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pen_row            <= 8'h00;
      screen_field_ident <= 8'h00;
      pen_send           <= 1'b0;
    end
    else
    begin
      pen_send <= do_pen; // [R9]
      if (do_pen)
      begin
        pen_row            <= word1; // [R9]
        screen_field_ident <= word2; // [R9]
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      por_send <= 1'b0;
    else
      por_send <= do_por; // [R10]
  end

  // ----------------------------------------
  // watch
  // ----------------------------------------
  logic watch_hit;

  tacu_watch u_watch
  (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .load_data   (do_wdata),
    .cmp_value   (word1),
    .cmp_mask    (word2),
    .load_addr   (do_waddr),
    .new_addr    ({word2[2:0], word1}),
    .cur_data    (watch_cur_data),
    .buf_wr      (buf_write_evt),
    .buf_wr_addr (buf_wr_addr),
    .buf_wr_data (buf_wr_data),
    .watch_addr  (watch_addr),
    .hit         (watch_hit)
  );

  // ----------------------------------------
  // primary status
  // ----------------------------------------
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  always_comb
  begin
    set_bits = 8'h00;
    set_bits[`TACU_ST_AUX_BIT]     = aux_change_evt; // [R3]
    set_bits[`TACU_ST_WATCH_BIT]   = watch_hit; // [R3] [R12]
    set_bits[`TACU_ST_KEYFREE_BIT] = key_slot_taken_evt;
    set_bits[`TACU_ST_RESET_BIT]   = unit_reset_evt; // [R3]
    set_bits[`TACU_ST_CMDIRQ_BIT]  = done;
    set_bits[`TACU_ST_MOD_BIT]     = buf_write_evt; // [R3]
    set_bits[`TACU_ST_CURSOR_BIT]  = cursor_set_evt; // [R3]
  end

  always_comb
  begin
    clr_bits = 8'h00;
    if (do_clr)
      clr_bits = word3; // [R1]
    clr_bits[`TACU_ST_KEYFREE_BIT] = clr_bits[`TACU_ST_KEYFREE_BIT] || do_key; // [R6]
    // command irq drops when a command begins and rises at its end
    clr_bits[`TACU_ST_CMDIRQ_BIT] = clr_bits[`TACU_ST_CMDIRQ_BIT] || exec;
  end

  // set beats clear so a coincident event is not lost
  assign next_status = ((status & ~clr_bits) | set_bits) & `TACU_ST_USED_MASK; // [R23] [R22]

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      status <= `TACU_ST_RESET_VAL;
    else
      status <= next_status; // [R4]
  end

  // ----------------------------------------
  // attention
  // ----------------------------------------
  logic [7:0] attn_mask;
  logic       attn_rise;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      attn_mask <= 8'h00;
    else if (do_amask)
      attn_mask <= word3; // [R16]
  end

  assign attn_rise = |(next_status & ~status & attn_mask); // [R16]

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      attention_req <= 1'b0;
    else if (attn_rise)
      attention_req <= 1'b1; // [R16] [R18]
    else if (io_wr && sel_flags)
      attention_req <= 1'b0; // [R18]
  end

  // ----------------------------------------
  // host read data
  // ----------------------------------------
  logic [1:0] rd_kind;
  logic [7:0] flags_byte;

  localparam logic [1:0] RD_NONE  = 2'd0;
  localparam logic [1:0] RD_STAT  = 2'd1;
  localparam logic [1:0] RD_MEM   = 2'd2;
  localparam logic [1:0] RD_FLAGS = 2'd3;

  always_comb
  begin
    flags_byte = 8'h00;
    flags_byte[`TACU_FLAG_ATTN_BIT] = attention_req; // [R19]
    flags_byte[`TACU_FLAG_PEND_BIT] = cmd_pending; // [R19]
  end

  // status and flags are sampled with the read, array data on the same edge inside the word array
  logic [7:0] rd_hold;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_kind <= RD_NONE;
      rd_hold <= 8'h00;
    end
    else if (io_rd)
    begin
      if (sel_word && word_idx == 2'd0)
      begin
        rd_kind <= RD_STAT;
        rd_hold <= status; // [R2] [R4]
      end
      else if (sel_word)
        rd_kind <= RD_MEM;
      else if (sel_flags)
      begin
        rd_kind <= RD_FLAGS;
        rd_hold <= flags_byte; // [R19]
      end
      else
      begin
        rd_kind <= RD_NONE;
        rd_hold <= 8'h00;
      end
    end
  end

  always_comb
  begin
    case (rd_kind)
      RD_MEM:   io_rdata = mem_rdata;
      RD_STAT:  io_rdata = rd_hold;
      RD_FLAGS: io_rdata = rd_hold;
      default:  io_rdata = 8'h00;
    endcase
  end

endmodule

/* design/tacu_consts.svh */
// constants for the terminal adapter command unit
// Overview of operation
// R1: clear-status command 3 clears every status bit masked by word 3
// R2: word 0 read after clear-status shows the cleared status
// R3: five sticky status bits stay set until cleared by command
// R4: word 0 always reads the live primary status
// R5: command 4 sends word 3 scan code to controller unchanged
// R6: send-keystroke clears the key slot free bit
// R7: host sends keystroke only while key slot free reads one
// R8: host checks pending flag before trusting key slot free
// R9: command 5 sends pen row (word 1) and field ident (word 2)
// R10: command 6 signals controller a fresh power-on reset
// R11: command 7 loads watch compare value and mask
// R12: masked compare of new write at watched location sets watch hit
// R13: zero mask captures current value and flags any later change; command 8 snapshots the data at the old watch address
// R14: command 8 loads watch address from words 1 and 2
// R15: host loads address after value and mask, then clears hit
// R16: command 9 loads attention mask; masked rising bits set attention
// R17: any write to 226H sets pending; device clears on acceptance
// R18: attention set by device only, cleared by write to 227H
// R19: read of 227H gives attention bit 7, pending bit 6
// R20: word 0 at 220H selects command; words 1 to 3 carry arguments
// R21: host leaves the array alone while pending is set
// R22: status bits 7 aux,6 watch,5 key free,3 reset,2 cmd,1 mod,0 cursor
// R23: a set condition beats a clear mask on the same bit
// R24: one command at a time; 226H writes ignored while pending
`ifndef TACU_CONSTS_SVH
`define TACU_CONSTS_SVH

// ----------------------------------------
// host i/o ports
// ----------------------------------------
`define TACU_PORT_WORD0     10'h220
`define TACU_PORT_WORD3     10'h223
`define TACU_PORT_CMD_POST  10'h226
`define TACU_PORT_FLAGS     10'h227
`define TACU_FLAG_ATTN_BIT  7
`define TACU_FLAG_PEND_BIT  6

// ----------------------------------------
// primary status bits
// ----------------------------------------
`define TACU_ST_AUX_BIT     7
`define TACU_ST_WATCH_BIT   6
`define TACU_ST_KEYFREE_BIT 5
`define TACU_ST_RESET_BIT   3
`define TACU_ST_CMDIRQ_BIT  2
`define TACU_ST_MOD_BIT     1
`define TACU_ST_CURSOR_BIT  0
`define TACU_ST_USED_MASK   8'hef
`define TACU_ST_RESET_VAL   8'h20

// ----------------------------------------
// command codes
// ----------------------------------------
`define TACU_CMD_CLR_STATUS 8'h03
`define TACU_CMD_SEND_KEY   8'h04
`define TACU_CMD_SEND_PEN   8'h05
`define TACU_CMD_POR        8'h06
`define TACU_CMD_WATCH_DATA 8'h07
`define TACU_CMD_WATCH_ADDR 8'h08
`define TACU_CMD_ATTN_MASK  8'h09

`endif

/* design/tacu_pkg.sv */
// types and shared functions for the terminal adapter command unit
package tacu_pkg;

  typedef enum logic [1:0] {
    TACU_IDLE,
    TACU_EXEC,
    TACU_DONE
  } tacu_state_t;

  typedef logic [7:0] tacu_byte_t;

  // nonzero where masked bits differ
  function automatic tacu_byte_t tacu_masked_diff(input tacu_byte_t a,
                                                 input tacu_byte_t b,
                                                 input tacu_byte_t m);
    tacu_masked_diff = (a ^ b) & m;
  endfunction

endpackage

/* design/tacu_watch.sv */
// buffer-location watch: masked compare or change detection
`timescale 1ns/1ps
module tacu_watch
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        load_data,
  input  wire logic [7:0]  cmp_value,
  input  wire logic [7:0]  cmp_mask,
  input  wire logic        load_addr,
  input  wire logic [10:0] new_addr,
  input  wire logic [7:0]  cur_data,
  input  wire logic        buf_wr,
  input  wire logic [10:0] buf_wr_addr,
  input  wire logic [7:0]  buf_wr_data,
  output logic      [10:0] watch_addr,
  output logic             hit
);

  logic [7:0] value;
  logic [7:0] mask;
  logic       at_loc;
  logic       zero_mask;

  assign zero_mask = (mask == 8'h00);
  assign at_loc    = buf_wr && (buf_wr_addr == watch_addr);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      mask <= 8'h00;
    else if (load_data)
      mask <= cmp_mask; // [R11]
  end

  // change mode keeps a snapshot, refreshed on each write to the location
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      value <= 8'h00;
    else if (load_data && cmp_mask == 8'h00)
      value <= cur_data; // [R13]
    else if (load_data)
      value <= cmp_value; // [R11]
    else if (load_addr && zero_mask)
      value <= cur_data; // [R13]
    else if (at_loc && zero_mask)
      value <= buf_wr_data;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      watch_addr <= 11'h000;
    else if (load_addr)
      watch_addr <= new_addr; // [R14]
  end

  always_comb
  begin
    if (zero_mask)
      hit = at_loc && (buf_wr_data != value); // [R13]
    else
      hit = at_loc && (tacu_pkg::tacu_masked_diff(buf_wr_data, value, mask) == 8'h00); // [R12]
  end

endmodule

/* design/tacu_word_mem.sv */
// four-word shared argument array with registered host read
`timescale 1ns/1ps
module tacu_word_mem
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data,
  output logic      [7:0] word1,
  output logic      [7:0] word2,
  output logic      [7:0] word3
);

  logic [7:0] mem [0:3];

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 4; i++)
        mem[i] <= 8'h00;
    end
    else if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rd_data <= 8'h00;
    else if (rd_en)
      rd_data <= mem[rd_idx];
  end

  assign word1 = mem[1];
  assign word2 = mem[2];
  assign word3 = mem[3];

endmodule

/* dv/tacu_cmd_asserts.sv */
// concurrent checks on the command unit host and controller ports
`timescale 1ns/1ps
module tacu_cmd_asserts
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [9:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        aux_change_evt,
  input wire logic [10:0] watch_addr,
  input wire logic [7:0]  key_code,
  input wire logic        key_send,
  input wire logic [7:0]  pen_row,
  input wire logic [7:0]  screen_field_ident,
  input wire logic        pen_send,
  input wire logic        por_send,
  input wire logic        attention_req,
  input wire logic        cmd_pending
);
  // ----
  // shadow of the host array, writes refused while busy
  // ----
  logic [7:0] w [4];

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      w <= '{default: 8'h00};
    else if (io_wr && !cmd_pending && io_addr[9:2] == 8'h88)
      w[io_addr[1:0]] <= io_wdata;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_post;
    io_wr && io_addr == 10'h226 && !cmd_pending;
  endsequence
  sequence s_busy;
    cmd_pending [*3] ##1 !cmd_pending;
  endsequence
  // no command may run between the event and the read, or a clear could race it
  sequence s_quiet_read;
    !cmd_pending ##1 (io_rd && io_addr == 10'h220 && !cmd_pending);
  endsequence

  property p_cmd_cycle;
    s_post |=> s_busy;
  endproperty
  property p_attn_fell;
    $fell(attention_req) |-> $past(io_wr && io_addr == 10'h227);
  endproperty
  property p_flags;
    io_rd && io_addr == 10'h227 |=>
      io_rdata == {$past(attention_req), $past(cmd_pending), 6'h00};
  endproperty
  property p_key;
    key_send |-> cmd_pending && w[0] == 8'h04 && key_code == w[3];
  endproperty
  property p_pen;
    pen_send |-> w[0] == 8'h05 && pen_row == w[1] && screen_field_ident == w[2];
  endproperty
  property p_por;
    por_send |-> cmd_pending && w[0] == 8'h06 && !key_send && !pen_send;
  endproperty
  property p_addr;
    $fell(cmd_pending) && w[0] == 8'h08 |-> watch_addr == {w[2][2:0], w[1]};
  endproperty
  property p_status;
    aux_change_evt ##1 s_quiet_read |=> io_rdata[7];
  endproperty

  a_cmd_cycle: assert property (p_cmd_cycle) else $error("busy flag timing");
  a_attn_fell: assert property (p_attn_fell) else $error("attention lost");
  a_flags: assert property (p_flags) else $error("flag read wrong");
  a_key: assert property (p_key) else $error("key code wrong");
  a_pen: assert property (p_pen) else $error("pen data wrong");
  a_por: assert property (p_por) else $error("reset signal wrong");
  a_addr: assert property (p_addr) else $error("watch address wrong");
  a_status: assert property (p_status) else $error("status not live");
endmodule

bind tacu_cmd_unit tacu_cmd_asserts u_tacu_cmd_asserts
(
  .core_clk           (core_clk),
  .resetn             (resetn),
  .io_addr            (io_addr),
  .io_wdata           (io_wdata),
  .io_wr              (io_wr),
  .io_rd              (io_rd),
  .io_rdata           (io_rdata),
  .aux_change_evt     (aux_change_evt),
  .watch_addr         (watch_addr),
  .key_code           (key_code),
  .key_send           (key_send),
  .pen_row            (pen_row),
  .screen_field_ident (screen_field_ident),
  .pen_send           (pen_send),
  .por_send           (por_send),
  .attention_req      (attention_req),
  .cmd_pending        (cmd_pending)
);

/* dv/tacu_ctrl_model.sv */
// controller-side model: slow key consumer and screen buffer
`timescale 1ns/1ps
module tacu_ctrl_model
#(
  parameter int KEY_DELAY = 20
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        key_send,
  output logic             key_slot_taken_evt,
  input  wire logic        buf_write_evt,
  input  wire logic [10:0] buf_wr_addr,
  input  wire logic [7:0]  buf_wr_data,
  input  wire logic [10:0] watch_addr,
  output logic      [7:0]  watch_cur_data
);
  logic [7:0] mem [2048];
  int         cnt;

  initial
    foreach (mem[i]) mem[i] = 8'h00;

  // slow consumption keeps the slot busy long enough to be seen
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      cnt <= 0;
      key_slot_taken_evt <= 1'b0;
    end
    else
    begin
      cnt <= key_send ? KEY_DELAY : (cnt > 0 ? cnt - 1 : 0);
      key_slot_taken_evt <= (cnt == 1);
    end

  always @(posedge core_clk)
    if (buf_write_evt)
      mem[buf_wr_addr] <= buf_wr_data;

  assign watch_cur_data = mem[watch_addr];
endmodule

/* dv/testbench.sv */
// self-checking bench for the command unit
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  io_addr = 10'h000;
  logic [7:0]  io_wdata = 8'h00;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic        ev = 1'b0;
  logic        bwr = 1'b0;
  logic [10:0] bwa = 11'h000;
  logic [7:0]  bwd = 8'h00;
  logic [7:0]  io_rdata, key_code, pen_row, fid, kc, cur, d;
  logic [10:0] watch_addr;
  logic        key_send, pen_send, por_send, attn, pend, taken;
  int          n_fail = 0, cmp_count = 0, n_key = 0, n_pen = 0, n_por = 0, cyc = 0;

  always #12.5 core_clk = ~core_clk;

  tacu_cmd_unit u_tacu_cmd_unit
  (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .io_addr            (io_addr),
    .io_wdata           (io_wdata),
    .io_wr              (io_wr),
    .io_rd              (io_rd),
    .io_rdata           (io_rdata),
    .aux_change_evt     (ev),
    .unit_reset_evt     (ev),
    .cursor_set_evt     (ev),
    .key_slot_taken_evt (taken),
    .buf_write_evt      (bwr),
    .buf_wr_addr        (bwa),
    .buf_wr_data        (bwd),
    .watch_cur_data     (cur),
    .watch_addr         (watch_addr),
    .key_code           (key_code),
    .key_send           (key_send),
    .pen_row            (pen_row),
    .screen_field_ident (fid),
    .pen_send           (pen_send),
    .por_send           (por_send),
    .attention_req      (attn),
    .cmd_pending        (pend)
  );

  tacu_ctrl_model u_tacu_ctrl_model
  (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .key_send           (key_send),
    .key_slot_taken_evt (taken),
    .buf_write_evt      (bwr),
    .buf_wr_addr        (bwa),
    .buf_wr_data        (bwd),
    .watch_addr         (watch_addr),
    .watch_cur_data     (cur)
  );

  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // run takes about 250 cycles; sampled mid-cycle so registered pulses are settled
  always @(negedge core_clk)
  begin
    cyc++;
    if (key_send)
      kc = key_code;
    n_key += key_send;
    n_pen += pen_send;
    n_por += por_send;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a);
    @(negedge core_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task automatic st(input logic [7:0] e);
    rd(10'h220);
    check(d, e);
  endtask

  task automatic idle();
    for (int i = 0; i < 20; i++)
    begin
      rd(10'h227);
      if (!d[6])
        break;
    end
    check(d[6], 1'b0);
    check(pend, 1'b0);
  endtask

  task automatic post(input logic [7:0] c, w1, w2, w3);
    wr(10'h221, w1);
    wr(10'h222, w2);
    wr(10'h223, w3);
    wr(10'h220, c);
    wr(10'h226, 8'h5a);
  endtask

  task automatic cmd(input logic [7:0] c, w1, w2, w3);
    post(c, w1, w2, w3);
    idle();
  endtask

  task automatic pulse();
    @(negedge core_clk);
    ev = 1'b1;
    @(negedge core_clk);
    ev = 1'b0;
  endtask

  task automatic bw(input logic [10:0] a, input logic [7:0] v);
    @(negedge core_clk);
    bwa = a;
    bwd = v;
    bwr = 1'b1;
    @(negedge core_clk);
    bwr = 1'b0;
    rd(10'h220);
  endtask

  initial
  begin
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    rd(10'h227);
    check(d, 8'h00);
    st(8'h20);
    pulse();
    bw(11'h010, 8'h11);
    check(d, 8'hab);
    cmd(8'h03, 8'h00, 8'h00, 8'h81);
    st(8'h2e);
    cmd(8'h09, 8'h00, 8'h00, 8'h80);
    rd(10'h227);
    check(d, 8'h00);
    pulse();
    st(8'haf);
    rd(10'h227);
    check(d, 8'h80);
    check(attn, 1'b1);
    wr(10'h227, 8'hff);
    rd(10'h227);
    check(d, 8'h00);
    cmd(8'h04, 8'h00, 8'h00, 8'h4d);
    st(8'h8f);
    check(kc, 8'h4d);
    check(11'(n_key), 11'h001);
    repeat (30) @(negedge core_clk);
    st(8'haf);
    post(8'h05, 8'h12, 8'h34, 8'h00);
    wr(10'h226, 8'h00);
    idle();
    check({pen_row, 3'h0}, {8'h12, 3'h0});
    check(fid, 8'h34);
    check(11'(n_pen), 11'h001);
    post(8'h06, 8'h12, 8'h34, 8'h00);
    wr(10'h221, 8'h99);
    idle();
    check(11'(n_por), 11'h001);
    rd(10'h221);
    check(d, 8'h12);
    cmd(8'h07, 8'h55, 8'hff, 8'h00);
    cmd(8'h08, 8'h23, 8'h01, 8'h00);
    cmd(8'h03, 8'h00, 8'h00, 8'h40);
    check(watch_addr, 11'h123);
    bw(11'h123, 8'h54);
    check(d[6], 1'b0);
    bw(11'h123, 8'h55);
    check(d[6], 1'b1);
    cmd(8'h07, 8'h00, 8'h00, 8'h00);
    cmd(8'h08, 8'h23, 8'h01, 8'h00);
    cmd(8'h03, 8'h00, 8'h00, 8'h40);
    bw(11'h123, 8'h55);
    check(d[6], 1'b0);
    bw(11'h123, 8'h56);
    check(d[6], 1'b1);
    rd(10'h225);
    check(d, 8'h00);
    conclude();
  end
endmodule
